/* design/adc_port_consts.svh */
// Purpose: Shared constants of the serial converter port
// Assumes: Included by bare name
// Notes: Counts in link bits or REF_CLK cycles
`ifndef ADC_PORT_CONSTS_SVH
`define ADC_PORT_CONSTS_SVH
`define ADC_CTRL_LAST 5'h07
`define ADC_FRAME_BITS 5'h10
`define ADC_RES_BITS 5'h0c
`define ADC_FILL 4'h0
`define ADC_CHAN_HI 6
`define ADC_CHAN_LO 4
`define ADC_UNI_BIT 3
`define ADC_SGL_BIT 2
`define ADC_PSEL_HI 1
`define ADC_PSEL_LO 0
`define ADC_REF_HZ 250000000
`define ADC_SCLK_HZ 4000000
`define ADC_HALF_DIV ((`ADC_REF_HZ + 2 * `ADC_SCLK_HZ - 1) / (2 * `ADC_SCLK_HZ))
`define ADC_STROBE_WAIT 5'h08
`endif

/* design/adc_port_pkg.sv */
// Purpose: Types of the serial converter port
// Assumes: Nothing
// Notes: Power encoding follows the two select bits
package adc_port_pkg;
  typedef enum logic [1:0] {FULL_PD, FAST_PD, REDUCED, NORMAL} power_t;
  typedef enum logic [1:0] {D_IDLE, D_CTRL, D_CONV, D_DONE} dev_state_t;
  typedef enum logic [2:0] {H_IDLE, H_CTRL, H_WAIT, H_READ, H_END} host_state_t;
endpackage

/* design/adc_link_if.sv */
// Purpose: Four-wire link plus strobe and shutdown pins between host and converter
// Assumes: Host makes sclk
// Notes: No clocking block
`timescale 1ns/1ps
interface adc_link_if;
  logic sclk;
  logic cs_n;
  logic din;
  logic dout;
  logic conv_strobe_out;
  logic hw_shutdown_n;
  modport host (output sclk, output cs_n, output din, output hw_shutdown_n,
                input dout, input conv_strobe_out);
  modport device (input sclk, input cs_n, input din, input hw_shutdown_n,
                  output dout, output conv_strobe_out);
endinterface

/* design/adc_converter_end.sv */
// Purpose: Converter end of the serial port: control byte in, result out
// Assumes: Host keeps clock phase 0, polarity 0
// Notes: Link logic runs on sclk; user side runs on REF_CLK
`timescale 1ns/1ps
`include "adc_port_consts.svh"
module adc_converter_end (
  // User clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Analog stand-in
  input wire logic [11:0] SAMPLE,
  // Status
  output logic BUSY,
  output logic [2:0] CHANNEL,
  output logic [1:0] POWER_MODE,
  // Link
  adc_link_if.device LINK
);

  // ----------------------------------------
  // Frame logic on rising sclk
  // ----------------------------------------
  logic frame_clr;
  adc_port_pkg::dev_state_t st;
  adc_port_pkg::dev_state_t next_st;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [5:0] ctrl_sr;
  logic [5:0] next_ctrl_sr;
  logic [15:0] result;
  logic [15:0] next_result;
  logic [11:0] sample_hold;
  logic start_ev;
  logic byte_ev;
  logic done_ev;
  logic [7:0] ctrl_byte;

  assign frame_clr = LINK.cs_n | ~LINK.hw_shutdown_n;
  assign start_ev = (st == adc_port_pkg::D_IDLE) && LINK.din;
  assign byte_ev = (st == adc_port_pkg::D_CTRL) && (cnt == `ADC_CTRL_LAST);
  assign done_ev = (st == adc_port_pkg::D_CONV) && (cnt == `ADC_FRAME_BITS);
  assign ctrl_byte = {1'b1, ctrl_sr, LINK.din};

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_ctrl_sr = ctrl_sr;
    next_result = result;
    case (st)
      adc_port_pkg::D_IDLE: begin
        if (start_ev) begin
          next_st = adc_port_pkg::D_CTRL;
          next_cnt = 5'h01;
        end
      end
      adc_port_pkg::D_CTRL: begin
        next_ctrl_sr = {ctrl_sr[4:0], LINK.din};
        next_cnt = cnt + 5'h01;
        if (byte_ev) begin
          next_st = adc_port_pkg::D_CONV;
          next_cnt = 5'h00;
          next_result = {sample_hold, `ADC_FILL};
        end
      end
      adc_port_pkg::D_CONV: begin
        if (done_ev) begin
          next_st = adc_port_pkg::D_DONE;
        end else begin
          next_cnt = cnt + 5'h01;
        end
      end
      default: begin
        next_st = adc_port_pkg::D_DONE;
      end
    endcase
  end

  always_ff @(posedge LINK.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      st <= adc_port_pkg::D_IDLE;
      cnt <= 5'h00;
      ctrl_sr <= 6'h00;
      result <= 16'h0000;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      ctrl_sr <= next_ctrl_sr;
      result <= next_result;
    end
  end

  // ----------------------------------------
  // Power state and events on rising sclk
  // ----------------------------------------
  adc_port_pkg::power_t mode;
  adc_port_pkg::power_t next_mode;
  adc_port_pkg::power_t pend;
  adc_port_pkg::power_t next_pend;
  logic [2:0] chan;
  logic [2:0] next_chan;
  logic conv_tgl;
  logic next_conv_tgl;
  logic done_tgl;
  logic next_done_tgl;

  always_comb begin
    next_mode = mode;
    next_pend = pend;
    next_chan = chan;
    next_conv_tgl = conv_tgl;
    next_done_tgl = done_tgl;
    if (start_ev) begin
      next_mode = adc_port_pkg::NORMAL;
    end
    if (byte_ev) begin
      next_pend = adc_port_pkg::power_t'({ctrl_byte[`ADC_PSEL_HI], ctrl_byte[`ADC_PSEL_LO]});
      next_chan = ctrl_byte[`ADC_CHAN_HI:`ADC_CHAN_LO];
      next_conv_tgl = ~conv_tgl;
    end
    if (done_ev) begin
      next_mode = pend;
      next_done_tgl = ~done_tgl;
    end
  end

  always_ff @(posedge LINK.sclk or negedge LINK.hw_shutdown_n) begin
    if (!LINK.hw_shutdown_n) begin
      mode <= adc_port_pkg::FULL_PD;
      pend <= adc_port_pkg::FULL_PD;
      chan <= 3'h0;
      conv_tgl <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      mode <= next_mode;
      pend <= next_pend;
      chan <= next_chan;
      conv_tgl <= next_conv_tgl;
      done_tgl <= next_done_tgl;
    end
  end

  // ----------------------------------------
  // Output pins on falling sclk
  // ----------------------------------------
  logic strobe;
  logic next_strobe;
  logic dout_r;
  logic next_dout;

  function automatic logic out_bit(input logic [15:0] w, input logic [4:0] n);
    logic [4:0] idx;
    idx = `ADC_FRAME_BITS - n;
    return w[idx[3:0]];
  endfunction

  always_comb begin
    next_strobe = (st == adc_port_pkg::D_CONV) && (cnt == 5'h00);
    next_dout = 1'b0;
    if ((st == adc_port_pkg::D_CONV) && (cnt != 5'h00)) begin
      next_dout = out_bit(result, cnt);
    end
  end

  always_ff @(negedge LINK.sclk or posedge frame_clr) begin
    if (frame_clr) begin
      strobe <= 1'b0;
      dout_r <= 1'b0;
    end else begin
      strobe <= next_strobe;
      dout_r <= next_dout;
    end
  end

  assign LINK.conv_strobe_out = strobe;
  assign LINK.dout = dout_r;

  // ----------------------------------------
  // User side on REF_CLK
  // ----------------------------------------
  logic cs_a;
  logic cs_b;
  logic sd_a;
  logic sd_b;
  logic ct_a;
  logic ct_b;
  logic ct_c;
  logic dt_a;
  logic dt_b;
  logic dt_c;
  logic [11:0] next_hold;
  logic next_busy;
  logic [2:0] next_channel;
  logic [1:0] next_power;

  always_comb begin
    next_hold = sample_hold;
    next_busy = BUSY;
    next_channel = CHANNEL;
    next_power = POWER_MODE;
    if (cs_b) begin
      next_hold = SAMPLE;
    end
    if (!sd_b) begin
      next_busy = 1'b0;
      next_power = adc_port_pkg::FULL_PD;
    end else begin
      if (ct_b ^ ct_c) begin
        next_busy = 1'b1;
        next_channel = chan;
        next_power = adc_port_pkg::NORMAL;
      end
      if (dt_b ^ dt_c) begin
        next_busy = 1'b0;
        next_power = mode;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cs_a <= 1'b1;
      cs_b <= 1'b1;
      sd_a <= 1'b0;
      sd_b <= 1'b0;
      {ct_a, ct_b, ct_c} <= 3'h0;
      {dt_a, dt_b, dt_c} <= 3'h0;
      sample_hold <= 12'h000;
      BUSY <= 1'b0;
      CHANNEL <= 3'h0;
      POWER_MODE <= adc_port_pkg::FULL_PD;
    end else begin
      cs_a <= LINK.cs_n;
      cs_b <= cs_a;
      sd_a <= LINK.hw_shutdown_n;
      sd_b <= sd_a;
      {ct_a, ct_b, ct_c} <= {conv_tgl, ct_a, ct_b};
      {dt_a, dt_b, dt_c} <= {done_tgl, dt_a, dt_b};
      sample_hold <= next_hold;
      BUSY <= next_busy;
      CHANNEL <= next_channel;
      POWER_MODE <= next_power;
    end
  end

endmodule // adc_converter_end

/* design/adc_host_end.sv */
// Purpose: Host end: sequences conversions and collects results
// Assumes: Converter end on the far side of the link
// Notes: sclk is divided from REF_CLK; two-entry result buffer
`timescale 1ns/1ps
`include "adc_port_consts.svh"
module adc_host_end (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Control
  input wire logic RUN,
  input wire logic SCAN_EN,
  input wire logic [2:0] CHANNEL,
  input wire logic UNIPOLAR,
  input wire logic SINGLE_ENDED,
  input wire logic [1:0] POWER_SEL,
  input wire logic SHUTDOWN,
  // Results
  output logic RESULT_VALID,
  output logic [11:0] RESULT_DATA,
  output logic [2:0] RESULT_CHAN,
  input wire logic RESULT_READY,
  output logic BUSY,
  // Link
  adc_link_if.host LINK
);

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  localparam logic [5:0] HALF_LAST = 6'(`ADC_HALF_DIV - 1);
  adc_port_pkg::host_state_t st;
  adc_port_pkg::host_state_t next_st;
  logic [5:0] div;
  logic [5:0] next_div;
  logic sclk_r, next_sclk, cs_n_r, next_cs_n, din_r, next_din, hw_shutdown_n_n_r, next_hw_shutdown_n_n;
  logic [7:0] ctrl_r, next_ctrl_r;
  logic [4:0] cnt, next_cnt;
  logic [11:0] shift, next_shift;
  logic [2:0] scan_ch, next_scan_ch, chan_cur, next_chan_cur;
  logic stb_prev, next_stb_prev;
  logic dout_a, dout_b, stb_a, stb_b;
  logic tick, rise, fall, push, t_v;
  logic [2:0] start_ch;

  assign tick = (div == HALF_LAST);
  assign rise = tick && !sclk_r;
  assign fall = tick && sclk_r;
  assign start_ch = SCAN_EN ? scan_ch : CHANNEL;
  assign push = (st == adc_port_pkg::H_END) && fall && (cnt == `ADC_FRAME_BITS);

  always_comb begin
    next_st = st;
    next_div = (st == adc_port_pkg::H_IDLE || tick) ? 6'h00 : div + 6'h01;
    next_sclk = (st != adc_port_pkg::H_IDLE && tick) ? ~sclk_r : sclk_r;
    next_cs_n = cs_n_r;
    next_din = din_r;
    next_ctrl_r = ctrl_r;
    next_cnt = cnt;
    next_shift = shift;
    next_scan_ch = scan_ch;
    next_chan_cur = chan_cur;
    next_stb_prev = stb_prev;
    next_hw_shutdown_n_n = ~SHUTDOWN;
    case (st)
      adc_port_pkg::H_IDLE: begin
        if (RUN && !SHUTDOWN && !t_v) begin
          next_cs_n = 1'b0;
          next_din = 1'b1;
          next_ctrl_r = {start_ch, UNIPOLAR, SINGLE_ENDED, POWER_SEL, 1'b0};
          next_chan_cur = start_ch;
          next_cnt = 5'h00;
          next_st = adc_port_pkg::H_CTRL;
        end
      end
      adc_port_pkg::H_CTRL: begin
        if (fall) begin
          next_cnt = cnt + 5'h01;
          next_din = ctrl_r[7];
          next_ctrl_r = {ctrl_r[6:0], 1'b0};
          if (cnt == `ADC_CTRL_LAST) begin
            next_din = 1'b0;
            next_cnt = 5'h00;
            next_stb_prev = 1'b0;
            next_st = adc_port_pkg::H_WAIT;
          end
        end
      end
      adc_port_pkg::H_WAIT: begin
        if (rise) begin
          next_stb_prev = stb_b;
          next_cnt = cnt + 5'h01;
          if (stb_prev && !stb_b) begin
            next_shift = {shift[10:0], dout_b};
            next_cnt = 5'h01;
            next_st = adc_port_pkg::H_READ;
          end else if (cnt == `ADC_STROBE_WAIT) begin
            next_st = adc_port_pkg::H_END;
          end
        end
      end
      adc_port_pkg::H_READ: begin
        if (rise) begin
          next_cnt = cnt + 5'h01;
          if (cnt < `ADC_RES_BITS) begin
            next_shift = {shift[10:0], dout_b};
          end
          if (cnt == `ADC_FRAME_BITS - 5'h01) begin
            next_st = adc_port_pkg::H_END;
          end
        end
      end
      default: begin
        if (fall) begin
          next_cs_n = 1'b1;
          next_st = adc_port_pkg::H_IDLE;
          if (SCAN_EN) begin
            next_scan_ch = chan_cur + 3'h1;
          end
        end
      end
    endcase
    if (SHUTDOWN) begin
      next_st = adc_port_pkg::H_IDLE;
      next_cs_n = 1'b1;
      next_sclk = 1'b0;
      next_din = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st <= adc_port_pkg::H_IDLE;
      div <= 6'h00;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      din_r <= 1'b0;
      hw_shutdown_n_n_r <= 1'b0;
      ctrl_r <= 8'h00;
      cnt <= 5'h00;
      shift <= 12'h000;
      scan_ch <= 3'h0;
      chan_cur <= 3'h0;
      stb_prev <= 1'b0;
      {dout_a, dout_b, stb_a, stb_b} <= 4'h0;
      BUSY <= 1'b0;
    end else begin
      st <= next_st;
      div <= next_div;
      sclk_r <= next_sclk;
      cs_n_r <= next_cs_n;
      din_r <= next_din;
      hw_shutdown_n_n_r <= next_hw_shutdown_n_n;
      ctrl_r <= next_ctrl_r;
      cnt <= next_cnt;
      shift <= next_shift;
      scan_ch <= next_scan_ch;
      chan_cur <= next_chan_cur;
      stb_prev <= next_stb_prev;
      {dout_a, dout_b} <= {LINK.dout, dout_a};
      {stb_a, stb_b} <= {LINK.conv_strobe_out, stb_a};
      BUSY <= (next_st != adc_port_pkg::H_IDLE);
    end
  end

  assign LINK.sclk = sclk_r;
  assign LINK.cs_n = cs_n_r;
  assign LINK.din = din_r;
  assign LINK.hw_shutdown_n = hw_shutdown_n_n_r;

  // ----------------------------------------
  // Two-entry result buffer
  // ----------------------------------------
  logic [14:0] t_d, next_t_d;
  logic next_h_v, next_t_v;
  logic [14:0] next_h_d;
  logic pop;

  assign pop = RESULT_VALID && RESULT_READY;

  always_comb begin
    next_h_v = RESULT_VALID;
    next_h_d = {RESULT_DATA, RESULT_CHAN};
    next_t_v = t_v;
    next_t_d = t_d;
    if (pop) begin
      next_h_v = t_v;
      next_h_d = t_d;
      next_t_v = 1'b0;
    end
    if (push) begin
      if (!next_h_v) begin
        next_h_v = 1'b1;
        next_h_d = {shift, chan_cur};
      end else begin
        next_t_v = 1'b1;
        next_t_d = {shift, chan_cur};
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      RESULT_VALID <= 1'b0;
      RESULT_DATA <= 12'h000;
      RESULT_CHAN <= 3'h0;
      t_v <= 1'b0;
      t_d <= 15'h0000;
    end else begin
      RESULT_VALID <= next_h_v;
      {RESULT_DATA, RESULT_CHAN} <= next_h_d;
      t_v <= next_t_v;
      t_d <= next_t_d;
    end
  end

endmodule // adc_host_end

/* testbench/adc_link_props.sv */
// Purpose: Link checks between host end and converter end
// Assumes: sclk, cs_n and hw_shutdown_n are host flops on REF_CLK
// Notes: Rising sclk edges are counted in the REF_CLK domain
`timescale 1ns/1ps
module adc_link_props (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic dout,
  input wire logic conv_strobe_out,
  input wire logic hw_shutdown_n
);
  logic sclk_q;
  logic next_sclk_q;
  logic [4:0] rises;
  logic [4:0] next_rises;
  always_comb begin
    next_sclk_q = sclk;
    next_rises = rises;
    if (cs_n) begin
      next_rises = 5'h00;
    end else if (sclk && !sclk_q) begin
      next_rises = rises + 5'h01;
    end
  end
  always_ff @(posedge REF_CLK) begin
    sclk_q <= next_sclk_q;
    rises <= next_rises;
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence s_high_half;
    ##32 ($fell(sclk) || !hw_shutdown_n);
  endsequence
  sequence s_strobe_high;
    conv_strobe_out throughout (##63 1'b1);
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_sclk_half_period: assert property ($rose(sclk) |-> s_high_half)
    else $error("sclk high phase wrong length");
  a_idle_quiet: assert property (cs_n |-> !sclk && !dout && !conv_strobe_out)
    else $error("link not quiet while deselected");
  a_start_bit_first: assert property ($fell(cs_n) |-> din)
    else $error("first bit after select is not high");
  a_strobe_after_byte: assert property ($rose(conv_strobe_out) |-> rises == 5'h08)
    else $error("strobe rose away from eighth clock");
  a_strobe_one_period: assert property ($rose(conv_strobe_out) |-> s_strobe_high ##1 !conv_strobe_out)
    else $error("strobe pulse not one clock period");
  a_dout_on_fall: assert property ($changed(dout) |-> $fell(sclk) || $rose(cs_n) || !hw_shutdown_n)
    else $error("dout changed off falling clock");
  a_frame_rises: assert property ($rose(cs_n) ##1 hw_shutdown_n |-> $past(rises) == 5'h19)
    else $error("frame did not last 25 clock rises");
  a_filler_zero: assert property (sclk && !sclk_q && !cs_n && rises >= 5'h15 && rises <= 5'h18 |-> !dout)
    else $error("filler bit not zero");
  a_shutdown_abort: assert property ($fell(hw_shutdown_n) |-> ##[0:1] (cs_n && !conv_strobe_out && !dout))
    else $error("shutdown did not end frame");
endmodule // adc_link_props

/* testbench/tb_top.sv */
// Purpose: Self-checking bench of host end and converter end
// Assumes: Both ends share REF_CLK; second converter bit-banged
// Notes: Second link clock has 6 ns period and also runs for eight bits while deselected
`timescale 1ns/1ps
module tb_top;
  logic ref_clk, rst, run, scan_en, unipolar, single_ended, shutdown, result_ready;
  logic result_valid, host_busy, cv_busy, cv2_busy, cs_prev;
  logic [2:0] channel, result_chan, cv_chan, cv2_chan;
  logic [1:0] power_sel, cv_mode, cv2_mode;
  logic [11:0] sample, sample2, result_data;
  logic [15:0] rd;
  logic q;
  int failures, samples_checked, i, frames;
  adc_link_if link ();
  adc_link_if link2 ();
  adc_host_end i_adc_host_end (.REF_CLK(ref_clk), .RST(rst), .RUN(run), .SCAN_EN(scan_en), .CHANNEL(channel),
    .UNIPOLAR(unipolar), .SINGLE_ENDED(single_ended), .POWER_SEL(power_sel), .SHUTDOWN(shutdown),
    .RESULT_VALID(result_valid), .RESULT_DATA(result_data), .RESULT_CHAN(result_chan),
    .RESULT_READY(result_ready), .BUSY(host_busy), .LINK(link));
  adc_converter_end i_adc_converter_end (.REF_CLK(ref_clk), .RST(rst), .SAMPLE(sample), .BUSY(cv_busy),
    .CHANNEL(cv_chan), .POWER_MODE(cv_mode), .LINK(link));
  adc_converter_end i_adc_converter_end_2 (.REF_CLK(ref_clk), .RST(rst), .SAMPLE(sample2), .BUSY(cv2_busy),
    .CHANNEL(cv2_chan), .POWER_MODE(cv2_mode), .LINK(link2));
  adc_link_props i_adc_link_props (.REF_CLK(ref_clk), .RST(rst), .sclk(link.sclk), .cs_n(link.cs_n),
    .din(link.din), .dout(link.dout), .conv_strobe_out(link.conv_strobe_out),
    .hw_shutdown_n(link.hw_shutdown_n));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task finish_test();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_until(input int k, input logic want);
    int n;
    n = 0;
    while (((k == 0) ? cv_busy : (k == 1) ? host_busy : result_valid) !== want) begin
      tick(1);
      n++;
      if (n > 5000) begin
        failures++;
        $display("BAD %0t wait ran out", $time);
        finish_test();
      end
    end
  endtask
  task pop(input logic [11:0] d, input logic [2:0] c);
    wait_until(2, 1'b1);
    check(16'(result_data), 16'(d));
    check(16'(result_chan), 16'(c));
    result_ready = 1'b1;
    tick(1);
    result_ready = 1'b0;
    tick(1);
  endtask
  task one_frame(input logic [1:0] ps, input logic [2:0] ch, input logic [11:0] smp);
    sample = smp;
    channel = ch;
    power_sel = ps;
    unipolar = ps[0];
    single_ended = ps[1];
    tick(4);
    run = 1'b1;
    tick(2);
    run = 1'b0;
    wait_until(0, 1'b1);
    check(16'(cv_mode), 16'h0003);
    pop(smp, ch);
    wait_until(1, 1'b0);
    tick(8);
    check(16'(cv_mode), 16'(ps));
    check(16'(cv_chan), 16'(ch));
  endtask
  task bit2(input logic b, output logic d);
    link2.din = b;
    #3 link2.sclk = 1'b1;
    d = link2.dout;
    #3 link2.sclk = 1'b0;
  endtask
  task frame2(input logic [7:0] ctl, input int lead, output logic [15:0] r);
    int j;
    link2.cs_n = 1'b0;
    #3;
    for (j = 0; j < lead; j++) bit2(1'b0, q);
    for (j = 7; j >= 0; j--) bit2(ctl[j], q);
    #1;
    check(16'(link2.conv_strobe_out), 16'h0001);
    bit2(1'b0, q);
    #1;
    check(16'(link2.conv_strobe_out), 16'h0000);
    for (j = 15; j >= 0; j--) begin
      bit2(j[0], q);
      r[j] = q;
    end
    link2.cs_n = 1'b1;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    {run, scan_en, unipolar, single_ended, shutdown, result_ready} = 6'h00;
    channel = 3'h0;
    power_sel = 2'h3;
    sample = 12'h000;
    sample2 = 12'h3c9;
    {link2.sclk, link2.cs_n, link2.din, link2.hw_shutdown_n} = 4'h4;
    tick(2);
    rst = 1'b0;
    link2.hw_shutdown_n = 1'b1;
    tick(6);
    one_frame(2'h3, 3'h5, 12'ha5c);
    for (i = 0; i < 4; i++) one_frame(2'(i), 3'(7 - i), 12'h801 ^ {12{i[1]}});
    sample = 12'hfff;
    scan_en = 1'b1;
    run = 1'b1;
    frames = 0;
    cs_prev = 1'b1;
    for (i = 0; i < 8000; i++) begin
      if (link.cs_n === 1'b0 && cs_prev === 1'b1) frames++;
      cs_prev = link.cs_n;
      tick(1);
    end
    check(16'(frames), 16'h0002);
    run = 1'b0;
    pop(12'hfff, 3'h0);
    pop(12'hfff, 3'h1);
    scan_en = 1'b0;
    wait_until(1, 1'b0);
    run = 1'b1;
    wait_until(0, 1'b1);
    shutdown = 1'b1;
    tick(6);
    check(16'({cv_busy, cv_mode}), 16'h0000);
    check(16'({link.cs_n, host_busy}), 16'h0002);
    run = 1'b0;
    tick(200);
    check(16'(result_valid), 16'h0000);
    shutdown = 1'b0;
    tick(8);
    one_frame(2'h2, 3'h1, 12'h000);
    for (i = 0; i < 8; i++) bit2(1'b1, q);
    tick(4);
    check(16'({cv2_busy, link2.conv_strobe_out}), 16'h0000);
    frame2(8'hdd, 3, rd);
    check(rd, {sample2, 4'h0});
    tick(8);
    check(16'(cv2_mode), 16'h0001);
    check(16'(cv2_chan), 16'h0005);
    finish_test();
  end
endmodule // tb_top
